// file: hw/fwbp_pkg.sv
// package: flash bus cycle codes, register map and timing for the buffer program controller
package fwbp_pkg;
    localparam int          FWBP_BUF_WORDS    = 32;
    localparam logic [15:0] FWBP_UNLOCK1_DATA = 16'h00AA;
    localparam logic [15:0] FWBP_UNLOCK2_DATA = 16'h0055;
    localparam logic [15:0] FWBP_LOAD_CMD     = 16'h0025;
    localparam logic [15:0] FWBP_CONFIRM_CMD  = 16'h0029;
    localparam logic [15:0] FWBP_ABORT_CMD    = 16'h00F0;
    localparam logic [15:0] FWBP_SUSPEND_CMD  = 16'h00B0;
    localparam logic [15:0] FWBP_RESUME_CMD   = 16'h0030;
    localparam logic [25:0] FWBP_UNLOCK1_ADDR = 26'h0000555;
    localparam logic [25:0] FWBP_UNLOCK2_ADDR = 26'h00002AA;
    // status bit positions in the polled word
    localparam int FWBP_POLL_BIT    = 7;
    localparam int FWBP_TOGGLE_BIT  = 6;
    localparam int FWBP_TIMEOUT_BIT = 5;
    localparam int FWBP_ABORT_BIT   = 1;
    // software register byte offsets
    localparam logic [7:0] FWBP_REG_CTRL   = 8'h00;
    localparam logic [7:0] FWBP_REG_ADDR   = 8'h04;
    localparam logic [7:0] FWBP_REG_COUNT  = 8'h08;
    localparam logic [7:0] FWBP_REG_STATUS = 8'h0C;
    localparam logic [7:0] FWBP_REG_IRQ    = 8'h10;
    localparam logic [7:0] FWBP_REG_MASK   = 8'h14;
    localparam logic [7:0] FWBP_REG_DATA0  = 8'h40;
    localparam logic [7:0] FWBP_REG_DATAN  = 8'hBC;
    // ctrl bits (write one to start)
    localparam int FWBP_CTRL_START   = 0;
    localparam int FWBP_CTRL_ABTCLR  = 1;
    localparam int FWBP_CTRL_SUSPEND = 2;
    localparam int FWBP_CTRL_RESUME  = 3;
    // interrupt bits
    localparam int FWBP_IRQ_DONE  = 0;
    localparam int FWBP_IRQ_ABORT = 1;
    localparam int FWBP_IRQ_FAIL  = 2;
    // bus cycle timing in ns, at a 4 ns clock
    localparam int FWBP_CLK_NS     = 4;
    localparam int FWBP_T_WP_NS    = 35;
    localparam int FWBP_T_SETUP_NS = 10;
    localparam int FWBP_T_RD_NS    = 100;
    localparam int FWBP_WP_CYC  = (FWBP_T_WP_NS + FWBP_CLK_NS - 1) / FWBP_CLK_NS;
    localparam int FWBP_SU_CYC  = (FWBP_T_SETUP_NS + FWBP_CLK_NS - 1) / FWBP_CLK_NS;
    localparam int FWBP_RD_CYC  = (FWBP_T_RD_NS + FWBP_CLK_NS - 1) / FWBP_CLK_NS;
endpackage

// file: hw/fwbp_cyc_if.sv
// interface between the sequencer and the flash bus cycle engine
`timescale 1ns/1ps
interface fwbp_cyc_if;
    logic        req;
    logic        wr;
    logic [25:0] addr;
    logic [15:0] wdata;
    logic        done;
    logic [15:0] rdata;
    modport seq (output req, output wr, output addr, output wdata, input done, input rdata);
    modport eng (input req, input wr, input addr, input wdata, output done, output rdata);
endinterface

// file: hw/fwbp_cycle.sv
// one flash bus cycle: timed write strobe or read with output enable
`timescale 1ns/1ps
module fwbp_cycle
    import fwbp_pkg::*;
(
    input  wire logic  clk_sys,
    input  wire logic  reset,
    fwbp_cyc_if.eng    cyc,
    output logic [25:0] f_addr,
    output logic [15:0] f_dq_out,
    output logic        f_dq_oe,
    input  wire logic [15:0] f_dq_in,
    output logic        f_chip_select_n,
    output logic        f_write_strobe_n,
    output logic        f_output_enable_n
);
    typedef enum logic [3:0] {
        FWBP_C_IDLE = 4'b0001, FWBP_C_SETUP = 4'b0010,
        FWBP_C_PULSE = 4'b0100, FWBP_C_HOLD = 4'b1000
    } fwbp_cyc_e;
    fwbp_cyc_e   state;
    logic [7:0]  cnt;
    logic [15:0] dq_s1;
    logic [15:0] dq_s2;

    // pin data are asynchronous to clk_sys
    always_ff @(posedge clk_sys) begin
        dq_s1 <= f_dq_in;
        dq_s2 <= dq_s1;
    end

    // address set with both strobes high, so it is latched on the later falling edge
    // and data on the first rising edge
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            state <= FWBP_C_IDLE;
            cnt <= 8'h00;
            f_addr <= 26'h0000000;
            f_dq_out <= 16'h0000;
            f_dq_oe <= 1'b0;
            f_chip_select_n <= 1'b1;
            f_write_strobe_n <= 1'b1;
            f_output_enable_n <= 1'b1;
            cyc.done <= 1'b0;
            cyc.rdata <= 16'h0000;
        end else begin
            cyc.done <= 1'b0;
            case (state)
                FWBP_C_IDLE: begin
                    if (cyc.req && !cyc.done) begin
                        f_addr <= cyc.addr;
                        f_dq_out <= cyc.wdata;
                        f_dq_oe <= cyc.wr;
                        cnt <= 8'(FWBP_SU_CYC);
                        state <= FWBP_C_SETUP;
                    end
                end
                FWBP_C_SETUP: begin
                    if (cnt == 8'h00) begin
                        f_chip_select_n <= 1'b0;
                        f_write_strobe_n <= ~cyc.wr;
                        f_output_enable_n <= cyc.wr;
                        cnt <= cyc.wr ? 8'(FWBP_WP_CYC) : 8'(FWBP_RD_CYC);
                        state <= FWBP_C_PULSE;
                    end else begin
                        cnt <= cnt - 8'h01;
                    end
                end
                FWBP_C_PULSE: begin
                    if (cnt == 8'h00) begin
                        cyc.rdata <= dq_s2;
                        f_chip_select_n <= 1'b1;
                        f_write_strobe_n <= 1'b1;
                        f_output_enable_n <= 1'b1;
                        cnt <= 8'(FWBP_SU_CYC);
                        state <= FWBP_C_HOLD;
                    end else begin
                        cnt <= cnt - 8'h01;
                    end
                end
                FWBP_C_HOLD: begin
                    if (cnt == 8'h00) begin
                        f_dq_oe <= 1'b0;
                        cyc.done <= 1'b1;
                        state <= FWBP_C_IDLE;
                    end else begin
                        cnt <= cnt - 8'h01;
                    end
                end
                default: state <= FWBP_C_IDLE;
            endcase
        end
    end

    property p_pin_roles;
        @(posedge clk_sys) disable iff (reset)
        f_dq_oe ? f_output_enable_n : f_write_strobe_n;
    endproperty
    a_pin_roles: assert property (p_pin_roles) else $error("dq driver clash");

    property p_cycle_stable;
        @(posedge clk_sys) disable iff (reset)
        !f_chip_select_n |=> f_chip_select_n || ($stable(f_addr) && $stable(f_dq_out));
    endproperty
    a_cycle_stable: assert property (p_cycle_stable) else $error("bus moved in strobe");
endmodule

// file: hw/fwbp_ctrl.sv
// host controller issuing buffered program sequences to a parallel flash
`timescale 1ns/1ps
module fwbp_ctrl
    import fwbp_pkg::*;
#(
    parameter int BUF_WORDS = FWBP_BUF_WORDS
) (
    input  wire logic        clk_sys,
    input  wire logic        reset,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic             irq,
    output logic [25:0]      f_addr,
    output logic [15:0]      f_dq_out,
    output logic             f_dq_oe,
    input  wire logic [15:0] f_dq_in,
    output logic             f_chip_select_n,
    output logic             f_write_strobe_n,
    output logic             f_output_enable_n
);
    typedef enum logic [10:0] {
        FWBP_IDLE  = 11'b00000000001, FWBP_UNL1 = 11'b00000000010,
        FWBP_UNL2  = 11'b00000000100, FWBP_CMD  = 11'b00000001000,
        FWBP_CNT   = 11'b00000010000, FWBP_LOAD = 11'b00000100000,
        FWBP_CONF  = 11'b00001000000, FWBP_POLL = 11'b00010000000,
        FWBP_SUSP  = 11'b00100000000, FWBP_RES  = 11'b01000000000,
        FWBP_ABT   = 11'b10000000000
    } fwbp_st_e;

    fwbp_cyc_if cyc ();
    fwbp_st_e    state;
    logic [25:0] base_addr;
    logic [5:0]  count;
    logic [5:0]  idx;
    logic [15:0] buf_mem [BUF_WORDS];
    logic        busy;
    logic        aborted;
    logic        abt_clr;
    logic        prev_tog;
    logic        prev_abt;
    logic        prev_tmo;
    logic        seen_poll;
    logic [2:0]  irq_stat;
    logic [2:0]  irq_mask;
    logic [2:0]  irq_set;
    logic        sus_req;
    logic        res_req;
    logic        go_req;
    logic        clr_req;
    logic        aw_hold;
    logic        w_hold;
    logic [7:0]  aw_a;
    logic [31:0] w_d;
    logic [3:0]  w_s;
    logic        wr_fire;
    logic [25:0] last_addr;
    logic [5:0]  words;

    fwbp_cycle u_cycle (
        .clk_sys           (clk_sys),
        .reset             (reset),
        .cyc               (cyc.eng),
        .f_addr            (f_addr),
        .f_dq_out          (f_dq_out),
        .f_dq_oe           (f_dq_oe),
        .f_dq_in           (f_dq_in),
        .f_chip_select_n   (f_chip_select_n),
        .f_write_strobe_n  (f_write_strobe_n),
        .f_output_enable_n (f_output_enable_n)
    );

    // ---- axi4-lite write channel: take address and data in either order
    assign wr_fire = aw_hold && w_hold && !s_axi_bvalid;
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            aw_hold <= 1'b0;
            w_hold <= 1'b0;
            aw_a <= 8'h00;
            w_d <= 32'h00000000;
            w_s <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'b00;
        end else begin
            s_axi_awready <= !aw_hold && !s_axi_awready && s_axi_awvalid;
            s_axi_wready <= !w_hold && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold <= 1'b1;
                aw_a <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold <= 1'b1;
                w_d <= s_axi_wdata;
                w_s <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_hold <= 1'b0;
                w_hold <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= 2'b00;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ---- software registers; data words are refused while a program runs
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            base_addr <= 26'h0000000;
            words <= 6'h01;
            irq_mask <= 3'h0;
        end else if (wr_fire && w_s[0]) begin
            if (aw_a == FWBP_REG_ADDR)
                base_addr <= w_d[25:0];
            // whole word compared so that 64 and up clamp instead of wrapping
            if (aw_a == FWBP_REG_COUNT)
                words <= (w_d > 32'(BUF_WORDS)) ? 6'(BUF_WORDS) :
                         (w_d[5:0] == 6'h00) ? 6'h01 : w_d[5:0];
            if (aw_a == FWBP_REG_MASK)
                irq_mask <= w_d[2:0];
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < BUF_WORDS; gi++) begin : g_buf
            always_ff @(posedge clk_sys) begin
                if (reset)
                    buf_mem[gi] <= 16'hFFFF;
                else if (wr_fire && !busy && aw_a == 8'(FWBP_REG_DATA0 + 4 * gi))
                    buf_mem[gi] <= w_d[15:0];
            end
        end
    endgenerate

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            go_req <= 1'b0;
            clr_req <= 1'b0;
            sus_req <= 1'b0;
            res_req <= 1'b0;
        end else begin
            if (wr_fire && aw_a == FWBP_REG_CTRL && w_s[0]) begin
                go_req <= go_req | w_d[FWBP_CTRL_START];
                clr_req <= clr_req | w_d[FWBP_CTRL_ABTCLR];
                sus_req <= sus_req | w_d[FWBP_CTRL_SUSPEND];
                res_req <= res_req | w_d[FWBP_CTRL_RESUME];
            end
            if (state == FWBP_IDLE && go_req && !cyc.req)
                go_req <= 1'b0;
            if ((state == FWBP_IDLE || state == FWBP_ABT) && clr_req && !cyc.req)
                clr_req <= 1'b0;
            if (state == FWBP_SUSP)
                sus_req <= 1'b0;
            if (state == FWBP_RES)
                res_req <= 1'b0;
        end
    end

    // ---- read channel
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= 2'b00;
        end else begin
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= 2'b00;
                case (s_axi_araddr)
                    FWBP_REG_ADDR:   s_axi_rdata <= {6'h00, base_addr};
                    FWBP_REG_COUNT:  s_axi_rdata <= {26'h0, words};
                    FWBP_REG_STATUS: s_axi_rdata <= {28'h0, state == FWBP_SUSP, aborted,
                                                     busy, state == FWBP_IDLE};
                    FWBP_REG_IRQ:    s_axi_rdata <= {29'h0, irq_stat};
                    FWBP_REG_MASK:   s_axi_rdata <= {29'h0, irq_mask};
                    default: begin
                        s_axi_rdata <= 32'h00000000;
                        if (s_axi_araddr >= FWBP_REG_DATA0 && s_axi_araddr <= FWBP_REG_DATAN)
                            s_axi_rdata <= {16'h0, buf_mem[5'(s_axi_araddr[7:2] - 6'h10)]};
                        else if (s_axi_araddr != FWBP_REG_CTRL)
                            s_axi_rresp <= 2'b10;
                    end
                endcase
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ---- sticky interrupts: set wins over the read that clears
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            irq_stat <= 3'h0;
            irq <= 1'b0;
        end else begin
            irq_stat <= ((s_axi_arvalid && s_axi_arready && s_axi_araddr == FWBP_REG_IRQ)
                         ? 3'h0 : irq_stat) | irq_set;
            irq <= |(irq_stat & irq_mask);
        end
    end

    // ---- sequencer
    assign busy = !(state == FWBP_IDLE || state == FWBP_ABT);
    assign last_addr = {base_addr[25:5], 5'(words - 6'h01)};

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            state <= FWBP_IDLE;
            cyc.req <= 1'b0;
            cyc.wr <= 1'b0;
            cyc.addr <= 26'h0000000;
            cyc.wdata <= 16'h0000;
            count <= 6'h00;
            idx <= 6'h00;
            aborted <= 1'b0;
            abt_clr <= 1'b0;
            prev_tog <= 1'b0;
            prev_abt <= 1'b0;
            prev_tmo <= 1'b0;
            seen_poll <= 1'b0;
            irq_set <= 3'h0;
        end else begin
            irq_set <= 3'h0;
            if (cyc.done)
                cyc.req <= 1'b0;
            if (!cyc.req && !cyc.done) begin
                case (state)
                    FWBP_IDLE, FWBP_ABT: begin
                        // a pending abort blocks new programs
                        if (clr_req || (go_req && state == FWBP_IDLE)) begin
                            abt_clr <= clr_req;
                            count <= words - 6'h01;
                            cyc.req <= 1'b1;
                            cyc.wr <= 1'b1;
                            cyc.addr <= base_addr + FWBP_UNLOCK1_ADDR;
                            cyc.wdata <= FWBP_UNLOCK1_DATA;
                            state <= FWBP_UNL1;
                        end
                    end
                    FWBP_UNL1: begin
                        cyc.req <= 1'b1;
                        cyc.addr <= base_addr + FWBP_UNLOCK2_ADDR;
                        cyc.wdata <= FWBP_UNLOCK2_DATA;
                        state <= FWBP_UNL2;
                    end
                    FWBP_UNL2: begin
                        cyc.req <= 1'b1;
                        cyc.addr <= abt_clr ? base_addr + FWBP_UNLOCK1_ADDR : base_addr;
                        cyc.wdata <= abt_clr ? FWBP_ABORT_CMD : FWBP_LOAD_CMD;
                        state <= abt_clr ? FWBP_IDLE : FWBP_CMD;
                        if (abt_clr)
                            aborted <= 1'b0;
                    end
                    FWBP_CMD: begin
                        cyc.req <= 1'b1;
                        cyc.addr <= base_addr;
                        cyc.wdata <= {10'h000, count};
                        idx <= 6'h00;
                        state <= FWBP_CNT;
                    end
                    FWBP_CNT, FWBP_LOAD: begin
                        // one load per counted word, in page order
                        cyc.req <= 1'b1;
                        if (state == FWBP_LOAD && idx == count + 6'h01) begin
                            cyc.addr <= last_addr;
                            cyc.wdata <= FWBP_CONFIRM_CMD;
                            state <= FWBP_CONF;
                        end else begin
                            cyc.addr <= {base_addr[25:5], idx[4:0]};
                            cyc.wdata <= buf_mem[idx[4:0]];
                            idx <= idx + 6'h01;
                            state <= FWBP_LOAD;
                        end
                    end
                    FWBP_CONF, FWBP_POLL, FWBP_RES: begin
                        // poll at the last loaded address; no other reads meanwhile
                        if (state != FWBP_CONF && seen_poll) begin
                            if (cyc.rdata[FWBP_TOGGLE_BIT] == prev_tog) begin
                                state <= FWBP_IDLE;
                                irq_set[FWBP_IRQ_DONE] <= 1'b1;
                            end else if (cyc.rdata[FWBP_ABORT_BIT] && prev_abt) begin
                                state <= FWBP_ABT;
                                aborted <= 1'b1;
                                irq_set[FWBP_IRQ_ABORT] <= 1'b1;
                            end else if (cyc.rdata[FWBP_TIMEOUT_BIT] && prev_tmo) begin
                                state <= FWBP_ABT;
                                aborted <= 1'b1;
                                irq_set[FWBP_IRQ_FAIL] <= 1'b1;
                            end
                        end
                        // flags need two reads, as array data after completion is not status;
                        // a suspend or resume write leaves no status behind
                        if (!cyc.wr) begin
                            prev_tog <= cyc.rdata[FWBP_TOGGLE_BIT];
                            prev_abt <= cyc.rdata[FWBP_ABORT_BIT];
                            prev_tmo <= cyc.rdata[FWBP_TIMEOUT_BIT];
                        end
                        seen_poll <= !cyc.wr;
                        cyc.wr <= 1'b0;
                        cyc.addr <= last_addr;
                        cyc.req <= 1'b1;
                        if (sus_req && state != FWBP_CONF) begin
                            // only suspend is heard while the algorithm runs
                            cyc.wr <= 1'b1;
                            cyc.wdata <= FWBP_SUSPEND_CMD;
                            state <= FWBP_SUSP;
                        end else if (state == FWBP_CONF) begin
                            state <= FWBP_POLL;
                        end
                    end
                    FWBP_SUSP: begin
                        seen_poll <= 1'b0;
                        if (res_req) begin
                            cyc.req <= 1'b1;
                            cyc.wr <= 1'b1;
                            cyc.addr <= base_addr;
                            cyc.wdata <= FWBP_RESUME_CMD;
                            state <= FWBP_RES;
                        end
                    end
                    default: state <= FWBP_IDLE;
                endcase
            end
        end
    end

    // the abort state is held until a clear sequence runs
    property p_abort_sticky;
        @(posedge clk_sys) disable iff (reset)
        (state == FWBP_ABT && !clr_req) |=> state == FWBP_ABT;
    endproperty
    a_abort_sticky: assert property (p_abort_sticky) else $error("abort state left");

    property p_confirm_code;
        @(posedge clk_sys) disable iff (reset)
        (state == FWBP_CONF && cyc.req) |-> cyc.wdata == FWBP_CONFIRM_CMD && cyc.addr == last_addr;
    endproperty
    a_confirm_code: assert property (p_confirm_code) else $error("bad confirm");

    property p_unlock_data;
        @(posedge clk_sys) disable iff (reset)
        (cyc.req && (state == FWBP_UNL1 || state == FWBP_UNL2)) |-> cyc.wr &&
            cyc.wdata == (state == FWBP_UNL1 ? FWBP_UNLOCK1_DATA : FWBP_UNLOCK2_DATA);
    endproperty
    a_unlock_data: assert property (p_unlock_data) else $error("bad unlock cycle");

    property p_count_word;
        @(posedge clk_sys) disable iff (reset)
        (state == FWBP_CNT && cyc.req) |-> cyc.wr && cyc.wdata < 16'(BUF_WORDS);
    endproperty
    a_count_word: assert property (p_count_word) else $error("count word too large");
endmodule

// file: sim/fwbp_flash_model.sv
// behavioural flash device answering buffered program sequences
`timescale 1ns/1ps
module fwbp_flash_model
    import fwbp_pkg::*;
(
    input  wire logic [25:0] f_addr,
    input  wire logic [15:0] f_dq_out,
    input  wire logic        f_chip_select_n,
    input  wire logic        f_write_strobe_n,
    input  wire logic        f_output_enable_n,
    input  wire logic        ab_req,
    output logic      [15:0] f_dq_in
);
    logic [15:0] mem [32], bf [32], cnt, last;
    logic [31:0] vld;
    logic [25:0] a, sa, pg;
    logic        ab = 0, tg = 0;
    int          st = 0, left = 0, busy = 0, nprog = 0;
    wire         wcyc = !f_write_strobe_n && !f_chip_select_n;
    initial begin
        foreach (mem[i]) mem[i] = 16'hFFFF;
        f_dq_in = 16'h0000;
    end
    always @(posedge wcyc) a = f_addr;
    always @(negedge wcyc) begin
        if (busy == 0) case (st)
            0: st = (f_dq_out == FWBP_UNLOCK1_DATA && a[11:0] == 12'h555) ? 1 : 0;
            1: st = (f_dq_out == FWBP_UNLOCK2_DATA && a[11:0] == 12'h2AA) ? 2 : 0;
            2: begin
                sa = a;
                if (f_dq_out == FWBP_ABORT_CMD) ab = 0;
                st = (f_dq_out == FWBP_LOAD_CMD && !ab) ? 3 : 0;
            end
            3: begin
                cnt = f_dq_out;
                left = cnt + 1;
                vld = 32'h0;
                ab = cnt >= FWBP_BUF_WORDS;
                st = ab ? 0 : 4;
            end
            4: begin
                if (left == cnt + 1) pg = a;
                if (a[25:5] != pg[25:5] || a[25:16] != sa[25:16]) ab = 1;
                bf[a[4:0]] = f_dq_out;
                vld[a[4:0]] = 1'b1;
                last = f_dq_out;
                left--;
                st = ab ? 0 : (left == 0) ? 5 : 4;
            end
            default: begin
                nprog++;
                st = 0;
                // the bench may order a refusal here to exercise the abort path
                if (f_dq_out != FWBP_CONFIRM_CMD || a[25:16] != sa[25:16] || ab_req) ab = 1;
                else begin
                    for (int i = 0; i < 32; i++) if (vld[i]) mem[i] &= bf[i];
                    busy = 3;
                end
            end
        endcase
    end
    always @(negedge f_output_enable_n) begin
        tg = ~tg;
        if (ab) f_dq_in = {8'h00, ~last[7], tg, 6'h02};
        else if (busy > 0) begin
            f_dq_in = {8'h00, ~last[7], tg, 6'h00};
            busy--;
        end else f_dq_in = mem[f_addr[4:0]];
    end
    // released bus must not keep showing the last word
    always @(posedge f_output_enable_n) f_dq_in = ~f_dq_in;
endmodule

// file: sim/tb.sv
// testbench: register access, buffered programs, interrupt and abort paths
`timescale 1ns/1ps
module tb;
    import fwbp_pkg::*;
    logic        clk_sys = 0, reset = 1, ab_req = 0, irq, f_dq_oe;
    logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic        s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready;
    logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic        f_chip_select_n, f_write_strobe_n, f_output_enable_n;
    logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [25:0] f_addr;
    logic [15:0] f_dq_out, f_dq_in, ex [32];
    logic [33:0] rd;
    int          fails = 0, n_compared = 0, cyc = 0;
    fwbp_ctrl dut (.clk_sys, .reset, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq, .f_addr, .f_dq_out, .f_dq_oe,
        .f_dq_in, .f_chip_select_n, .f_write_strobe_n, .f_output_enable_n);
    fwbp_flash_model flash (.f_addr, .f_dq_out, .f_chip_select_n, .f_write_strobe_n,
        .f_output_enable_n, .ab_req, .f_dq_in);
    initial forever #2 clk_sys = ~clk_sys;
    // a full run needs a few thousand cycles
    always @(posedge clk_sys) if (++cyc == 40000) begin
        fails++;
        complete_run;
    end
    task automatic complete_run;
        $display("compared %0d, mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input logic [33:0] got, input logic [33:0] exp);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        forever begin
            @(posedge clk_sys);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        s_axi_bready <= 1'b0;
    endtask
    task automatic rdr(input logic [7:0] a, output logic [33:0] d);
        @(posedge clk_sys);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        forever begin
            @(posedge clk_sys);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        d = {s_axi_rresp, s_axi_rdata};
        s_axi_rready <= 1'b0;
    endtask
    task automatic prog(input logic [15:0] seed, input logic [31:0] n, input logic [31:0] c);
        for (int i = 0; i < 32; i++) begin
            wr(FWBP_REG_DATA0 + 8'(4 * i), {16'h0000, seed ^ 16'(i)});
            ex[i] &= seed ^ 16'(i);
        end
        wr(FWBP_REG_COUNT, n);
        wr(FWBP_REG_CTRL, c);
    endtask
    task automatic finish_and_check(input int k);
        while (irq !== 1'b1) @(posedge clk_sys);
        chk(flash.nprog, k);
        rdr(FWBP_REG_IRQ, rd); chk(rd, 34'h1);
        rdr(FWBP_REG_IRQ, rd); chk(rd, 34'h0);
        chk(irq, 34'h0);
        foreach (ex[i]) chk(flash.mem[i], ex[i]);
        chk(flash.cnt, 34'h1F);
    endtask
    initial begin
        foreach (ex[i]) ex[i] = 16'hFFFF;
        repeat (4) @(posedge clk_sys);
        reset <= 1'b0;
        rdr(FWBP_REG_STATUS, rd); chk(rd, 34'h1);
        rdr(8'h30, rd); chk(rd, 34'h200000000);
        wr(FWBP_REG_ADDR, 32'h120000);
        prog(16'hA5C3, 32, 32'h1);
        do rdr(FWBP_REG_STATUS, rd); while (flash.nprog != 1 || rd[1] !== 1'b0);
        chk(irq, 34'h0);
        wr(FWBP_REG_MASK, 32'h3);
        finish_and_check(1);
        prog(16'h3C0F, 40, 32'h1);
        finish_and_check(2);
        prog(16'hFF00, 32, 32'h5);
        do rdr(FWBP_REG_STATUS, rd); while (rd[3] !== 1'b1);
        chk(flash.busy > 0, 34'h1);
        wr(FWBP_REG_CTRL, 32'h8);
        finish_and_check(3);
        ab_req <= 1'b1;
        wr(FWBP_REG_COUNT, 32'h1);
        wr(FWBP_REG_CTRL, 32'h1);
        while (irq !== 1'b1) @(posedge clk_sys);
        rdr(FWBP_REG_IRQ, rd); chk(rd, 34'h2);
        rdr(FWBP_REG_STATUS, rd); chk(rd[2], 34'h1);
        chk(flash.cnt, 34'h0);
        ab_req <= 1'b0;
        wr(FWBP_REG_CTRL, 32'h2);
        // status drops as the clear cycle starts; wait until its strobe is over
        do rdr(FWBP_REG_STATUS, rd); while (rd[2] !== 1'b0 || dut.cyc.req !== 1'b0);
        chk(flash.ab, 34'h0);
        complete_run;
    end
endmodule
